/* logic/bcdrtc_pkg.sv */
// Purpose: Shared constants and types for the BCD calendar timer
// Assumes: 32.768 kHz class source, prescalers 128 x 256 give one second
// Notes:   Calendar fields other than subseconds are BCD
package bcdrtc_pkg;
  typedef enum logic [1:0] {
    BCDRTC_SRC_XTAL, BCDRTC_SRC_RESON, BCDRTC_SRC_LSI, BCDRTC_SRC_HSE
  } bcdrtc_src_t;

  typedef struct packed {
    logic [14:0] subsec;
    logic [6:0]  sec;
    logic [6:0]  min;
    logic        pm;
    logic [5:0]  hour;
    logic [2:0]  wday;
    logic [5:0]  date;
    logic [4:0]  month;
    logic [7:0]  year;
  } bcdrtc_cal_t;

  // Mask bits: 0 seconds, 1 minutes, 2 hours, 3 date
  typedef struct packed {
    logic [6:0] sec;
    logic [6:0] min;
    logic       pm;
    logic [5:0] hour;
    logic [5:0] date;
    logic [3:0] mask;
  } bcdrtc_alarm_t;

  localparam logic [6:0]  BCDRTC_ASYNC_DIV = 7'h7F;
  localparam logic [14:0] BCDRTC_SYNC_DIV  = 15'h00FF;
  localparam logic [4:0]  BCDRTC_HSE_DIV   = 5'h1F;
  localparam logic [5:0]  BCDRTC_REF50_MAX = 6'h31;
  localparam logic [5:0]  BCDRTC_REF60_MAX = 6'h3B;
  localparam logic [10:0] BCDRTC_CAL_SLOT  = 11'h000;
  localparam logic [10:0] BCDRTC_INS_SLOT  = 11'h400;
  localparam int          BCDRTC_BKP_WORDS = 5;
  localparam bcdrtc_cal_t BCDRTC_CAL_RESET = '{subsec: 15'h00FF, sec: 7'h00, min: 7'h00,
                                               pm: 1'b0, hour: 6'h00, wday: 3'h1,
                                               date: 6'h01, month: 5'h01, year: 8'h00};
endpackage : bcdrtc_pkg

/* logic/bcdrtc_core.sv */
// Purpose: BCD calendar timer with alarm, shift, calibration, tamper,
//          timestamp, mains reference and retained backup words
// Assumes: All pin inputs are asynchronous to core_clk
// Notes:   Backup words have no reset at all
//
// Functional notes
// RL1: Five 32-bit backup words, 20 bytes
// RL2: Backup words survive every reset
// RL3: Calendar subseconds to year, BCD fields
// RL4: Hours in 12-hour or 24-hour form
// RL5: Month length from month and leap year
// RL6: Programmable alarm can wake from Stop
// RL7: One-time shift by 1 to 32767 pulses
// RL8: Periodic pulse add/remove, 1 ppm calibration
// RL9: Two filtered tamper inputs, wake capable
// RL10: Timestamp copies calendar on pin or tamper
// RL11: Timestamp event can wake from Stop
// RL12: 50/60 Hz reference aligns seconds
// RL13: Clock from four selectable sources
// RL14: Alarm flag on unmasked field match
`timescale 1ns/10ps
module bcdrtc_core import bcdrtc_pkg::*; (
  input  wire logic          core_clk,
  input  wire logic          reset_n,
  input  wire logic          xtalIn,
  input  wire logic          resonIn,
  input  wire logic          lsiIn,
  input  wire logic          hseIn,
  input  wire bcdrtc_src_t   clkSel,
  input  wire logic          tamper_input_one,
  input  wire logic          tamper_input_two,
  input  wire logic          timestamp_input,
  input  wire logic          mains_reference_input,
  input  wire logic          fmt12,
  input  wire logic          setReq,
  input  wire bcdrtc_cal_t   setValue,
  input  wire bcdrtc_alarm_t alarmCfg,
  input  wire logic          alarmEn,
  input  wire logic          alarmIe,
  input  wire logic          alarmClr,
  input  wire logic          shiftReq,
  input  wire logic [14:0]   shiftAmt,
  input  wire logic          shiftAdd1s,
  input  wire logic          calPlus,
  input  wire logic [8:0]    calMinus,
  input  wire logic          refEn,
  input  wire logic          ref60,
  input  wire logic [1:0]    tampEn,
  input  wire logic [1:0]    tampLevel,
  input  wire logic [1:0]    tampFilter,
  input  wire logic          tampTsEn,
  input  wire logic          tampIe,
  input  wire logic [1:0]    tampClr,
  input  wire logic          tsEn,
  input  wire logic          tsFalling,
  input  wire logic          tsIe,
  input  wire logic          tsClr,
  input  wire logic          bkpWe,
  input  wire logic [2:0]    bkpIdx,
  input  wire logic [31:0]   bkpWdata,
  output logic [31:0]        bkpRdata,
  output bcdrtc_cal_t        calendar,
  output bcdrtc_cal_t        tsStamp,
  output logic               shiftBusy,
  output logic               alarmFlag,
  output logic [1:0]         tampFlag,
  output logic               tsFlag,
  output logic               tsOvf,
  output logic               alarmIrq,
  output logic               wakeup
);
  function automatic logic [7:0] bcdInc(input logic [7:0] v);
    bcdInc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction : bcdInc

  function automatic logic [5:0] monthDays(input logic [4:0] m, input logic [7:0] y);
    logic leap;
    leap = (!y[4] && (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8)) ||
           (y[4] && (y[3:0] == 4'h2 || y[3:0] == 4'h6)); // RL5
    if (m == 5'h02)
      monthDays = leap ? 6'h29 : 6'h28; // RL5
    else if (m == 5'h04 || m == 5'h06 || m == 5'h09 || m == 5'h11)
      monthDays = 6'h30;
    else
      monthDays = 6'h31;
  endfunction : monthDays

  // Two-stage synchronisers, then an edge history stage
  logic [7:0] pinA_reg, pinB_reg, pinC_reg, rise, fall;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinA_reg <= 8'h00;
      pinB_reg <= 8'h00;
      pinC_reg <= 8'h00;
    end else begin
      pinA_reg <= {mains_reference_input, timestamp_input, tamper_input_two,
                   tamper_input_one, hseIn, lsiIn, resonIn, xtalIn};
      pinB_reg <= pinA_reg;
      pinC_reg <= pinB_reg;
    end
  end
  assign rise = pinB_reg & ~pinC_reg;
  assign fall = ~pinB_reg & pinC_reg;

  // Time base, shift, calibration and calendar
  bcdrtc_cal_t cal_reg, cal_next;
  logic [6:0]  async_reg, async_next;
  logic [4:0]  hse_reg, hse_next;
  logic [14:0] shift_reg, shift_next;
  logic [19:0] calCnt_reg, calCnt_next;
  logic [5:0]  refCnt_reg, refCnt_next;
  logic        ins_reg, ins_next, secTickD_reg;
  logic        rawPulse, tick, secTick, refSec;

  always_comb begin
    hse_next    = hse_reg;
    rawPulse    = 1'b0;
    unique case (clkSel) // RL13
      BCDRTC_SRC_XTAL:  rawPulse = rise[0];
      BCDRTC_SRC_RESON: rawPulse = rise[1];
      BCDRTC_SRC_LSI:   rawPulse = rise[2];
      BCDRTC_SRC_HSE: begin
        if (rise[3]) begin
          hse_next = hse_reg + 5'h01;
          rawPulse = (hse_reg == BCDRTC_HSE_DIV); // RL13
        end
      end
    endcase
    calCnt_next = rawPulse ? calCnt_reg + 20'h00001 : calCnt_reg;
    // Remove calMinus pulses per 2^20, insert 512 extra when calPlus set
    ins_next = rawPulse && calPlus && calCnt_reg[10:0] == BCDRTC_INS_SLOT; // RL8
    shift_next = shift_reg;
    tick = ins_reg; // RL8
    if (rawPulse) begin
      if (shift_reg != 15'h0000)
        shift_next = shift_reg - 15'h0001; // RL7
      else if (!(calCnt_reg[10:0] == BCDRTC_CAL_SLOT && calCnt_reg[19:11] < calMinus))
        tick = 1'b1; // RL8
    end
    if (shiftReq && shift_reg == 15'h0000)
      shift_next = shiftAmt; // RL7
    refCnt_next = refCnt_reg;
    refSec      = 1'b0;
    if (refEn && rise[7]) begin
      refSec      = refCnt_reg == (ref60 ? BCDRTC_REF60_MAX : BCDRTC_REF50_MAX); // RL12
      refCnt_next = refSec ? 6'h00 : refCnt_reg + 6'h01;
    end
    cal_next  = cal_reg;
    async_next = async_reg;
    secTick   = refSec || (shiftReq && shiftAdd1s && shift_reg == 15'h0000); // RL7
    if (tick) begin
      async_next = async_reg - 7'h01;
      if (async_reg == 7'h00) begin
        async_next = BCDRTC_ASYNC_DIV;
        cal_next.subsec = cal_reg.subsec - 15'h0001; // RL3
        if (cal_reg.subsec == 15'h0000) begin
          cal_next.subsec = BCDRTC_SYNC_DIV;
          if (!refEn)
            secTick = 1'b1;
        end
      end
    end
    if (refSec) begin
      cal_next.subsec = BCDRTC_SYNC_DIV; // RL12
      async_next      = BCDRTC_ASYNC_DIV;
    end
    if (secTick) begin
      cal_next.sec = (cal_reg.sec == 7'h59) ? 7'h00 : 7'(bcdInc({1'b0, cal_reg.sec})); // RL3
      if (cal_reg.sec == 7'h59) begin
        cal_next.min = (cal_reg.min == 7'h59) ? 7'h00 : 7'(bcdInc({1'b0, cal_reg.min}));
        if (cal_reg.min == 7'h59) begin
          if (fmt12) begin // RL4
            cal_next.hour = (cal_reg.hour == 6'h12) ? 6'h01 : 6'(bcdInc({2'b00, cal_reg.hour}));
            if (cal_reg.hour == 6'h11)
              cal_next.pm = ~cal_reg.pm; // RL4
          end else begin
            cal_next.hour = (cal_reg.hour == 6'h23) ? 6'h00 : 6'(bcdInc({2'b00, cal_reg.hour}));
          end
          if (fmt12 ? (cal_reg.hour == 6'h11 && cal_reg.pm) : cal_reg.hour == 6'h23) begin
            cal_next.wday = (cal_reg.wday == 3'h7) ? 3'h1 : cal_reg.wday + 3'h1;
            if (cal_reg.date == monthDays(cal_reg.month, cal_reg.year)) begin // RL5
              cal_next.date  = 6'h01;
              cal_next.month = (cal_reg.month == 5'h12) ? 5'h01 :
                               5'(bcdInc({3'b000, cal_reg.month}));
              if (cal_reg.month == 5'h12)
                cal_next.year = (cal_reg.year == 8'h99) ? 8'h00 : bcdInc(cal_reg.year);
            end else begin
              cal_next.date = 6'(bcdInc({2'b00, cal_reg.date}));
            end
          end
        end
      end
    end
    if (setReq) begin
      cal_next   = setValue;
      async_next = BCDRTC_ASYNC_DIV;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cal_reg      <= BCDRTC_CAL_RESET;
      async_reg    <= BCDRTC_ASYNC_DIV;
      hse_reg      <= 5'h00;
      shift_reg    <= 15'h0000;
      calCnt_reg   <= 20'h00000;
      refCnt_reg   <= 6'h00;
      ins_reg      <= 1'b0;
      secTickD_reg <= 1'b0;
    end else begin
      cal_reg      <= cal_next;
      async_reg    <= async_next;
      hse_reg      <= hse_next;
      shift_reg    <= shift_next;
      calCnt_reg   <= calCnt_next;
      refCnt_reg   <= refCnt_next;
      ins_reg      <= ins_next;
      secTickD_reg <= secTick;
    end
  end

  // Tamper filters: 0 edge mode, else 2/4/8 equal samples on time base ticks
  logic [1:0] tampEv;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_tamp
      logic [3:0] cnt_reg, cnt_next;
      logic       act, ev;
      assign act = pinB_reg[4 + gi] ^ ~tampLevel[gi];
      always_comb begin
        cnt_next = cnt_reg;
        ev       = 1'b0;
        if (tampFilter == 2'b00) begin
          ev = tampLevel[gi] ? rise[4 + gi] : fall[4 + gi]; // RL9
        end else if (!act) begin
          cnt_next = 4'h0;
        end else if (tick && cnt_reg != 4'hF) begin
          cnt_next = cnt_reg + 4'h1;
          ev       = (cnt_reg + 4'h1) == (4'h1 << tampFilter); // RL9
        end
      end
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n)
          cnt_reg <= 4'h0;
        else
          cnt_reg <= cnt_next;
      end
      assign tampEv[gi] = ev && tampEn[gi];
    end
  endgenerate

  // Event flags, timestamp capture and wake outputs
  bcdrtc_cal_t ts_next;
  logic        alarmHit, tsEv, alarmF_next, tsF_next, tsOvf_next;
  logic [1:0]  tampF_next;
  always_comb begin
    alarmHit = alarmEn && secTickD_reg &&
               (alarmCfg.mask[0] || alarmCfg.sec == cal_reg.sec) &&
               (alarmCfg.mask[1] || alarmCfg.min == cal_reg.min) &&
               (alarmCfg.mask[2] || (alarmCfg.hour == cal_reg.hour &&
                                     (!fmt12 || alarmCfg.pm == cal_reg.pm))) &&
               (alarmCfg.mask[3] || alarmCfg.date == cal_reg.date); // RL14
    tsEv = (tsEn && (tsFalling ? fall[6] : rise[6])) || (tampTsEn && |tampEv); // RL10
    alarmF_next = alarmHit || (alarmFlag && !alarmClr); // RL14
    tampF_next  = tampEv | (tampFlag & ~tampClr); // RL9
    tsF_next    = tsEv || (tsFlag && !tsClr);
    tsOvf_next  = (tsEv && tsFlag) || (tsOvf && !tsClr);
    ts_next     = tsEv ? cal_reg : tsStamp; // RL10
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      alarmFlag <= 1'b0;
      tampFlag  <= 2'b00;
      tsFlag    <= 1'b0;
      tsOvf     <= 1'b0;
      tsStamp   <= BCDRTC_CAL_RESET;
      calendar  <= BCDRTC_CAL_RESET;
      shiftBusy <= 1'b0;
      alarmIrq  <= 1'b0;
      wakeup    <= 1'b0;
    end else begin
      alarmFlag <= alarmF_next;
      tampFlag  <= tampF_next;
      tsFlag    <= tsF_next;
      tsOvf     <= tsOvf_next;
      tsStamp   <= ts_next;
      calendar  <= cal_next;
      shiftBusy <= shift_next != 15'h0000;
      alarmIrq  <= alarmF_next && alarmIe;
      wakeup    <= (alarmF_next && alarmIe) || (|tampF_next && tampIe) || // RL6 RL9
                   (tsF_next && tsIe); // RL11
    end
  end

  // Retained backup words: deliberately no reset branch
  logic [31:0] bkpMem [BCDRTC_BKP_WORDS]; // RL1
  always_ff @(posedge core_clk) begin
    if (bkpWe && bkpIdx < 3'(BCDRTC_BKP_WORDS))
      bkpMem[bkpIdx] <= bkpWdata; // RL2
    bkpRdata <= (bkpIdx < 3'(BCDRTC_BKP_WORDS)) ? bkpMem[bkpIdx] : 32'h0000_0000;
  end
endmodule : bcdrtc_core

/* tb/bcdrtc_monitor.sv */
// Purpose: Port-level checks on the calendar timer
// Assumes: One clock domain, async active-low reset
// Notes:   Bound into every core instance
`timescale 1ns/10ps
module bcdrtc_monitor import bcdrtc_pkg::*; (
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic        fmt12,
  input wire logic        setReq,
  input wire bcdrtc_cal_t setValue,
  input wire logic        alarmIe,
  input wire logic        alarmClr,
  input wire logic        shiftReq,
  input wire logic [14:0] shiftAmt,
  input wire logic [1:0]  tampClr,
  input wire logic [2:0]  bkpIdx,
  input wire logic [31:0] bkpRdata,
  input wire bcdrtc_cal_t calendar,
  input wire logic        shiftBusy,
  input wire logic        alarmFlag,
  input wire logic [1:0]  tampFlag,
  input wire logic        tsFlag,
  input wire logic        tsOvf,
  input wire logic        alarmIrq,
  input wire logic        wakeup
);
  default clocking mcb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  chk_load_value: assert property (setReq |=> calendar == $past(setValue))
    else $error("calendar differs from loaded value");
  chk_hour_twelve: assert property (fmt12 && $past(fmt12) |->
    calendar.hour != 6'h00 && calendar.hour <= 6'h12)
    else $error("hour outside 12-hour range");
  chk_alarm_sticky: assert property (alarmFlag && !alarmClr |=> alarmFlag)
    else $error("alarm flag dropped without clear");
  chk_alarm_irq: assert property ($rose(alarmFlag) && alarmIe |-> alarmIrq && wakeup)
    else $error("alarm hit without irq or wake");
  chk_tamp_sticky: assert property (tampFlag[0] && !tampClr[0] |=> tampFlag[0])
    else $error("tamper flag dropped without clear");
  chk_wake_cause: assert property ($rose(wakeup) |-> alarmFlag || tsFlag || (|tampFlag))
    else $error("wake request without a flag");
  chk_ts_overrun: assert property ($rose(tsOvf) |-> $past(tsFlag))
    else $error("overrun without earlier stamp");
  chk_bkp_range: assert property (bkpIdx > 3'h4 |=> bkpRdata == 32'h00000000)
    else $error("unmapped backup index read nonzero");
  chk_busy_start: assert property (shiftReq && !shiftBusy && shiftAmt != 15'h0000
    |=> shiftBusy)
    else $error("shift accepted but not busy");
  cov_alarm: cover property ($rose(alarmFlag));
  cov_overrun: cover property ($rose(tsOvf));
  cov_shift: cover property ($fell(shiftBusy));
endmodule : bcdrtc_monitor
bind bcdrtc_core bcdrtc_monitor i_mon (.core_clk, .reset_n, .fmt12, .setReq, .setValue,
  .alarmIe, .alarmClr, .shiftReq, .shiftAmt, .tampClr, .bkpIdx, .bkpRdata, .calendar,
  .shiftBusy, .alarmFlag, .tampFlag, .tsFlag, .tsOvf, .alarmIrq, .wakeup);

/* tb/bcdrtc_far_end.sv */
// Purpose: Pins driven from outside the calendar timer
// Assumes: Source clock runs free, mains reference only when asked
// Notes:   Switch and stamp levels come from the bench
`timescale 1ns/10ps
module bcdrtc_far_end (
  input  wire logic       core_clk,
  input  wire logic       refRun,
  input  wire logic [2:0] pinCmd,
  output logic            srcClk,
  output logic            mains_reference_input,
  output logic            tamper_input_one,
  output logic            tamper_input_two,
  output logic            timestamp_input
);
  logic [1:0] divReg = 2'h0;
  always @(posedge core_clk) divReg <= divReg + 2'h1;
  assign srcClk = divReg[1];
  assign mains_reference_input = refRun & divReg[1];
  assign {tamper_input_one, tamper_input_two, timestamp_input} = pinCmd;
endmodule : bcdrtc_far_end

/* tb/tb_top.sv */
// Purpose: Self-checking bench for the calendar timer
// Assumes: Mains reference paces seconds to keep runs short
// Notes:   Backup words checked across a mid-run reset
`timescale 1ns/10ps
module tb_top import bcdrtc_pkg::*; ;
  logic          core_clk, reset_n, fmt12, setReq, alarmEn, alarmIe, alarmClr, shiftReq;
  logic          shiftAdd1s, refEn, ref60, tampTsEn, tampIe, tsEn, tsFalling, tsIe, tsClr;
  logic          bkpWe, refRun, shiftBusy, alarmFlag, tsFlag, tsOvf, alarmIrq, wakeup;
  logic          srcClk, mains_reference_input, timestamp_input;
  logic          tamper_input_one, tamper_input_two;
  logic [1:0]    tampEn, tampClr, tampFlag, tampFilter;
  logic [2:0]    bkpIdx, pinCmd;
  logic [14:0]   shiftAmt;
  logic [31:0]   bkpWdata, bkpRdata;
  bcdrtc_cal_t   setValue, calendar, tsStamp, v;
  bcdrtc_alarm_t alarmCfg;
  int            err_count = 0;
  int            checks = 0;
  bcdrtc_core i_dut (.core_clk, .reset_n, .xtalIn(srcClk), .resonIn(srcClk), .lsiIn(srcClk),
    .hseIn(srcClk), .clkSel(BCDRTC_SRC_XTAL), .tamper_input_one, .tamper_input_two,
    .timestamp_input, .mains_reference_input, .fmt12, .setReq, .setValue, .alarmCfg,
    .alarmEn, .alarmIe, .alarmClr, .shiftReq, .shiftAmt, .shiftAdd1s, .calPlus(1'b0),
    .calMinus(9'h000), .refEn, .ref60, .tampEn, .tampLevel(2'h3), .tampFilter,
    .tampTsEn, .tampIe, .tampClr, .tsEn, .tsFalling, .tsIe, .tsClr, .bkpWe, .bkpIdx,
    .bkpWdata, .bkpRdata, .calendar, .tsStamp, .shiftBusy, .alarmFlag, .tampFlag, .tsFlag,
    .tsOvf, .alarmIrq, .wakeup);
  bcdrtc_far_end i_far (.core_clk, .refRun, .pinCmd, .srcClk, .mains_reference_input,
    .tamper_input_one, .tamper_input_two, .timestamp_input);
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  task automatic cmp(input string nm, input logic [63:0] exp, input logic [63:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : cmp
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  task automatic wait_sec();
    logic [6:0] old;
    old = calendar.sec;
    for (int i = 0; i < 400 && calendar.sec === old; i++) cyc(1);
    cmp("second tick", 1'b1, calendar.sec !== old);
    if (calendar.sec === old) stop_test();
  endtask : wait_sec
  task automatic load(input logic [5:0] h, input logic [6:0] m, input logic [6:0] s);
    v = BCDRTC_CAL_RESET;
    {v.hour, v.min, v.sec} = {h, m, s};
    setValue = v;
    setReq = 1'b1;
    cyc(1);
    setReq = 1'b0;
  endtask : load
  task automatic t_backup();
    for (int i = 0; i < 5; i++) begin
      {bkpWe, bkpIdx, bkpWdata} = {1'b1, 3'(i), 32'hC0DE0000 | 32'(i)};
      cyc(1);
    end
    bkpWe = 1'b0;
    reset_n = 1'b0;
    cyc(2);
    cmp("calendar reset", BCDRTC_CAL_RESET, calendar);
    reset_n = 1'b1;
    for (int i = 0; i < 6; i++) begin
      bkpIdx = 3'(i);
      cyc(1);
      cmp("backup word", (i < 5) ? 32'hC0DE0000 | 32'(i) : 32'h0, bkpRdata);
    end
    $display("test backup done");
  endtask : t_backup
  task automatic t_roll();
    logic [39:0] tab [5] = '{40'h0302280301, 40'h0402280229, 40'h0402290301,
                             40'h0404300501, 40'h0412310101};
    {refEn, refRun} = 2'b11;
    foreach (tab[i]) begin
      v = BCDRTC_CAL_RESET;
      {v.hour, v.min, v.sec} = {6'h23, 7'h59, 7'h59};
      {v.year, v.month, v.date} = {tab[i][39:32], tab[i][28:24], tab[i][21:16]};
      setValue = v;
      setReq = 1'b1;
      cyc(1);
      setReq = 1'b0;
      wait_sec();
      cmp("month and date", tab[i][15:0], {3'h0, calendar.month, 2'h0, calendar.date});
      cmp("time of day", 20'h0, {calendar.hour, calendar.min, calendar.sec});
    end
    cmp("year", 8'h05, calendar.year);
    $display("test rollover done");
  endtask : t_roll
  task automatic t_twelve();
    {fmt12, ref60} = 2'b11;
    load(6'h11, 7'h59, 7'h59);
    wait_sec();
    cmp("hour and pm", {1'b1, 6'h12}, {calendar.pm, calendar.hour});
    {fmt12, ref60} = 2'b00;
    $display("test twelve done");
  endtask : t_twelve
  task automatic t_alarm();
    alarmCfg = '{sec: 7'h59, min: 7'h01, pm: 1'b0, hour: 6'h10, date: 6'h01, mask: 4'h0};
    {alarmEn, alarmIe} = 2'b11;
    for (int k = 0; k < 2; k++) begin
      load(6'h10, 7'h00, 7'h58);
      wait_sec();
      cyc(3);
      cmp("alarm outputs", {3{k[0]}}, {alarmFlag, alarmIrq, wakeup});
      alarmCfg.mask = 4'h2;
    end
    alarmClr = 1'b1;
    cyc(1);
    {alarmClr, alarmEn} = 2'b00;
    cyc(2);
    cmp("alarm cleared", 3'h0, {alarmFlag, alarmIrq, wakeup});
    $display("test alarm done");
  endtask : t_alarm
  task automatic t_tamper();
    {refRun, tampEn, tampTsEn, tampIe, tsEn, tsIe, tsFalling} = 8'h3F;
    load(6'h08, 7'h42, 7'h17);
    pinCmd = 3'h7;
    cyc(6);
    cmp("tamper flags", 2'b01, tampFlag);
    cmp("stamp and wake", 3'h5, {tsFlag, tsOvf, wakeup});
    cmp("stamp value", v[42:0], tsStamp[42:0]);
    pinCmd = 3'h0;
    cyc(6);
    cmp("stamp overrun", 2'b11, {tsFlag, tsOvf});
    {tampClr, tsClr} = 3'h7;
    cyc(1);
    {tampClr, tsClr} = 3'h0;
    cyc(3);
    cmp("flags cleared", 5'h00, {tampFlag, tsFlag, tsOvf, wakeup});
    $display("test tamper done");
  endtask : t_tamper
  task automatic t_filter();
    {tampFilter, tampEn, tampTsEn} = {2'h1, 2'b10, 1'b0};
    pinCmd = 3'h2;
    cyc(20);
    cmp("filtered tamper", 2'b10, tampFlag);
    {pinCmd, tampClr} = {3'h0, 2'h3};
    cyc(1);
    tampClr = 2'h0;
    cyc(2);
    cmp("filter cleared", 2'b00, tampFlag);
    $display("test filter done");
  endtask : t_filter
  task automatic t_shift();
    refEn = 1'b0;
    load(6'h01, 7'h00, 7'h10);
    {shiftAmt, shiftAdd1s, shiftReq} = {15'h0003, 2'b11};
    cyc(1);
    {shiftAdd1s, shiftReq} = 2'b00;
    cyc(1);
    cmp("shift state", {1'b1, 7'h11}, {shiftBusy, calendar.sec});
    for (int i = 0; i < 100 && shiftBusy === 1'b1; i++) cyc(1);
    cmp("shift done", 1'b0, shiftBusy);
    if (shiftBusy !== 1'b0) stop_test();
    $display("test shift done");
  endtask : t_shift
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    {reset_n, fmt12, setReq, alarmEn, alarmIe, alarmClr, shiftReq, shiftAdd1s} = 8'h00;
    {refEn, ref60, tampTsEn, tampIe, tsEn, tsIe, tsClr, bkpWe, refRun, tsFalling} = 10'h000;
    {tampEn, tampClr, bkpIdx, pinCmd, shiftAmt, bkpWdata} = 57'h0;
    {setValue, alarmCfg} = {BCDRTC_CAL_RESET, 31'h0};
    tampFilter = 2'h0;
    cyc(10);
    reset_n = 1'b1;
    cyc(1);
    t_backup();
    t_roll();
    t_twelve();
    t_alarm();
    t_tamper();
    t_filter();
    t_shift();
    stop_test();
  end
endmodule : tb_top
